// ### src/rsc_strobe_decoder.sv
// Serial strobe, register and queue decoder of the radio transceiver
// Behaviour
// [RULE_01] 16-bit config registers default on any chip reset
// [RULE_02] Main register reset by pin only
// [RULE_03] Host writes reset bit low then high
// [RULE_04] Fifteen strobe addresses start state changes; code has fourteen strobes 0x00-0x0D, 0x0E and 0x0F fire but do nothing
// [RULE_05] Thirty-three ordinary 16-bit registers provided
// [RULE_06] Two byte queue registers, transmit write-only
// [RULE_07] Raw memory read keeps transmit bytes queued
// [RULE_08] Host uses queues only with oscillator on
// [RULE_09] Status byte out during address, transmit writes
// [RULE_10] Strobe 0x00 only returns status
// [RULE_11] Strobe 0x01 clears both powerdown bits
// [RULE_12] Strobe 0x02 calibrates, waits synthesizer only
// [RULE_13] 0x03 enables receive; 0x06 disables radio
// [RULE_14] 0x04 transmits, calibrates, encrypts when secured
// [RULE_15] 0x05 transmits only on clear channel
// [RULE_16] Strobe 0x07 turns oscillator and radio off
// [RULE_17] Strobe 0x08 empties receive queue, resets demod
// [RULE_18] Host reads one receive byte before flush
// [RULE_19] Strobe 0x09 empties transmit queue
// [RULE_20] 0x0A/0x0B send acknowledge, pending clear/set
// [RULE_21] Strobe 0x0C starts receive decryption
// [RULE_22] Strobe 0x0D starts transmit encryption, no send
`timescale 1ns/10ps
module rsc_strobe_decoder (
    // Clock and reset
    input  wire logic               core_clk_i,
    input  wire logic               rst_i,
    // Pins from the host
    input  wire logic               chip_reset_low_i,
    input  wire logic               spi_select_low_i,
    input  wire logic               spi_clk_i,
    input  wire logic               spi_din_i,
    output logic                    spi_dout_o,
    // Radio core side
    input  wire logic               cca_clear_i,
    input  wire logic               tx_done_i,
    input  wire logic               tx_pop_i,
    input  wire logic               rx_push_i,
    input  wire logic [7:0]         rx_data_i,
    output logic [7:0]              tx_data_o,
    output rsc_pkg::rsc_radio_t     radio_o,
    output logic [13:0]             act_o,
    output logic                    enc_start_o
);

    rsc_pkg::rsc_state_t s;
    rsc_pkg::rsc_state_t next_s;
    logic                fire;
    logic [3:0]          faddr;
    logic                csn_fall;
    logic                ram_byte;
    logic [7:0]          stat;

    // =====================================================
    // Next state
    always_comb begin
        logic [7:0]  ab;
        logic [15:0] word;
        logic [15:0] rv;
        logic [5:0]  ix;
        logic        osc;
        logic        secure;
        logic        sclk_rise;
        logic        sel_rise;
        logic        hw_rst;
        logic        tx_in;
        logic        tx_out;
        logic        rx_in;
        logic        rx_out;
        ab        = {s.sin[6:0], s.si_s[2]};
        word      = {s.sin[14:0], s.si_s[2]};
        rv        = 16'h0000;
        ix        = s.addr[5:0];
        tx_in     = 1'b0;
        rx_out    = 1'b0;
        fire      = 1'b0;
        faddr     = rsc_pkg::ST_NOP;
        ram_byte  = 1'b0;
        next_s    = s;
        osc       = !s.main_reg[rsc_pkg::MAIN_OSC_PD]
                    && !s.main_reg[rsc_pkg::MAIN_BIAS_POWERDOWN];
        secure    = s.cfg[5'(rsc_pkg::ADDR_SEC - rsc_pkg::ADDR_CFG_LO)]
                    [1:0] != 2'b00;
        tx_out    = tx_pop_i && s.tx_cnt != 8'h00;
        rx_in     = rx_push_i && s.rx_cnt != rsc_pkg::QUEUE_DEPTH;
        sclk_rise = s.sclk_s[1] == s.sclk_s[2] && s.sclk_s[2]
                    && !s.sclk_lv;
        csn_fall  = s.sel_s[1] == s.sel_s[2] && !s.sel_s[2] && s.sel_lv;
        sel_rise  = s.sel_s[1] == s.sel_s[2] && s.sel_s[2] && !s.sel_lv;
        hw_rst    = s.rst_s[1] == s.rst_s[2] && !s.rst_s[2];
        stat      = 8'h00;
        stat[rsc_pkg::STAT_OSC] = osc;
        stat[rsc_pkg::STAT_TX]  = s.rstate == rsc_pkg::RS_TX;
        stat[rsc_pkg::STAT_SYN] = s.radio.synth_en;
        next_s.act       = 14'h0000;
        next_s.enc_start = 1'b0;

        // Pin synchronisers; a level counts once stages two and three agree
        next_s.sel_s  = {s.sel_s[1:0], spi_select_low_i};
        next_s.sclk_s = {s.sclk_s[1:0], spi_clk_i};
        next_s.si_s   = {s.si_s[1:0], spi_din_i};
        next_s.rst_s  = {s.rst_s[1:0], chip_reset_low_i};
        if (s.sel_s[1] == s.sel_s[2]) begin
            next_s.sel_lv = s.sel_s[2];
        end
        if (s.sclk_s[1] == s.sclk_s[2]) begin
            next_s.sclk_lv = s.sclk_s[2];
        end

        // =================================================
        // Serial engine
        if (sel_rise) begin
            next_s.phase = rsc_pkg::SP_IDLE;
        end else if (csn_fall) begin
            next_s.phase = rsc_pkg::SP_ADDR;
            next_s.bits  = 5'd0;
            next_s.sout  = {stat, 8'h00};                       // [RULE_09]
        end else if (sclk_rise && s.phase != rsc_pkg::SP_IDLE) begin
            next_s.sin  = word;
            next_s.sout = {s.sout[14:0], 1'b0};
            next_s.bits = s.bits + 5'd1;
            if (s.phase == rsc_pkg::SP_ADDR && s.bits == 5'd7) begin
                next_s.addr  = ab;
                next_s.bits  = 5'd0;
                next_s.phase = rsc_pkg::SP_DATA;
                next_s.sout  = {stat, 8'h00};                   // [RULE_09]
                if (ab[rsc_pkg::RAM_BIT]) begin
                    next_s.ram_ix = ab[6:0];
                    next_s.sout   = {s.txm[ab[6:0]], 8'h00};    // [RULE_07]
                end else if (ab[5:0] < rsc_pkg::ADDR_MAIN) begin
                    fire         = 1'b1;                        // [RULE_04]
                    faddr        = ab[3:0];
                    next_s.phase = rsc_pkg::SP_ADDR;
                end else if (ab[5:0] == rsc_pkg::ADDR_RXQ) begin
                    next_s.sout = {s.rxm[s.rx_rd], 8'h00};      // [RULE_06]
                    rx_out      = osc && s.rx_cnt != 8'h00;     // [RULE_08]
                end else if (ab[5:0] != rsc_pkg::ADDR_TXQ) begin
                    if (ab[5:0] == rsc_pkg::ADDR_MAIN) begin
                        rv = s.main_reg;
                    end else if (ab[5:0] == rsc_pkg::ADDR_FSM) begin
                        rv = {11'h000, s.rstate};
                    end else if (ab[5:0] <= rsc_pkg::ADDR_CFG_HI) begin
                        rv = s.cfg[5'(ab[5:0] - rsc_pkg::ADDR_CFG_LO)];
                    end
                    next_s.sout = rv;                           // [RULE_05]
                end
            end else if (s.phase == rsc_pkg::SP_DATA) begin
                if (s.addr[rsc_pkg::RAM_BIT] || ix >= rsc_pkg::ADDR_TXQ)
                begin
                    if (s.bits == 5'd7) begin
                        next_s.bits = 5'd0;
                        if (s.addr[rsc_pkg::RAM_BIT]) begin
                            ram_byte      = 1'b1;               // [RULE_07]
                            next_s.ram_ix = s.ram_ix + 7'd1;
                            next_s.sout   = {s.txm[next_s.ram_ix], 8'h00};
                        end else if (ix == rsc_pkg::ADDR_TXQ) begin
                            tx_in = osc && !s.addr[rsc_pkg::READ_BIT]
                                    && s.tx_cnt != rsc_pkg::QUEUE_DEPTH;
                            next_s.sout = {stat, 8'h00};        // [RULE_09]
                        end else begin
                            next_s.sout = {s.rxm[s.rx_rd], 8'h00};
                            rx_out      = osc && s.rx_cnt != 8'h00;
                        end
                    end
                end else if (s.bits == 5'd15) begin
                    next_s.bits  = 5'd0;
                    next_s.phase = rsc_pkg::SP_ADDR;
                    next_s.sout  = {stat, 8'h00};
                    if (!s.addr[rsc_pkg::READ_BIT]) begin
                        if (ix == rsc_pkg::ADDR_MAIN) begin
                            next_s.main_reg = word;             // [RULE_02]
                        end else if (ix != rsc_pkg::ADDR_FSM
                                     && ix <= rsc_pkg::ADDR_CFG_HI) begin
                            next_s.cfg[5'(ix - rsc_pkg::ADDR_CFG_LO)] = word;
                        end
                    end
                end
            end
        end

        // =================================================
        // Byte queues
        if (tx_in) begin
            next_s.txm[s.tx_wr] = ab;                           // [RULE_06]
            next_s.tx_wr        = s.tx_wr + 7'd1;
        end
        if (tx_out) begin
            next_s.tx_rd = s.tx_rd + 7'd1;
        end
        next_s.tx_cnt = s.tx_cnt + {7'h00, tx_in} - {7'h00, tx_out};
        if (rx_in) begin
            next_s.rxm[s.rx_wr] = rx_data_i;
            next_s.rx_wr        = s.rx_wr + 7'd1;
        end
        if (rx_out) begin
            next_s.rx_rd = s.rx_rd + 7'd1;
        end
        next_s.rx_cnt = s.rx_cnt + {7'h00, rx_in} - {7'h00, rx_out};

        // =================================================
        // Radio state
        if (!osc) begin
            next_s.rstate = rsc_pkg::RS_OFF;
        end else if (s.rstate == rsc_pkg::RS_OFF) begin
            next_s.rstate = rsc_pkg::RS_IDLE;
        end else if (s.rstate == rsc_pkg::RS_TX && tx_done_i) begin
            next_s.rstate = rsc_pkg::RS_RX;
        end
        if (fire) begin
            case (faddr)
                rsc_pkg::ST_NOP: begin
                end                                             // [RULE_10]
                rsc_pkg::ST_OSC_ON: begin
                    next_s.main_reg[rsc_pkg::MAIN_OSC_PD]  = 1'b0; // [RULE_11]
                    next_s.main_reg[rsc_pkg::MAIN_BIAS_POWERDOWN] = 1'b0;
                    next_s.act[faddr]                      = 1'b1;
                end
                rsc_pkg::ST_TX_CAL: begin
                    if (osc) begin
                        next_s.rstate     = rsc_pkg::RS_CAL;    // [RULE_12]
                        next_s.calibrated = 1'b1;
                        next_s.act[faddr] = 1'b1;
                    end
                end
                rsc_pkg::ST_RX_ON: begin
                    if (osc) begin
                        next_s.rstate     = rsc_pkg::RS_RX;     // [RULE_13]
                        next_s.act[faddr] = 1'b1;
                    end
                end
                rsc_pkg::ST_TX_ON, rsc_pkg::ST_TX_CCA: begin
                    if (osc && (faddr == rsc_pkg::ST_TX_ON
                                || cca_clear_i)) begin          // [RULE_15]
                        next_s.rstate     = rsc_pkg::RS_TX;     // [RULE_14]
                        next_s.calibrated = 1'b1;
                        next_s.enc_start  = secure;
                        next_s.act[faddr] = 1'b1;
                    end
                end
                rsc_pkg::ST_RF_OFF: begin
                    if (osc) begin
                        next_s.rstate     = rsc_pkg::RS_IDLE;   // [RULE_13]
                        next_s.calibrated = 1'b0;
                        next_s.act[faddr] = 1'b1;
                    end
                end
                rsc_pkg::ST_OSC_OFF: begin
                    next_s.main_reg[rsc_pkg::MAIN_OSC_PD]  = 1'b1; // [RULE_16]
                    next_s.main_reg[rsc_pkg::MAIN_BIAS_POWERDOWN] = 1'b1;
                    next_s.rstate                          = rsc_pkg::RS_OFF;
                    next_s.calibrated                      = 1'b0;
                    next_s.act[faddr]                      = 1'b1;
                end
                rsc_pkg::ST_RX_FLUSH: begin
                    next_s.rx_wr      = 7'd0;                   // [RULE_17]
                    next_s.rx_rd      = 7'd0;
                    next_s.rx_cnt     = 8'h00;
                    next_s.act[faddr] = 1'b1;
                end
                rsc_pkg::ST_TX_FLUSH: begin
                    next_s.tx_wr      = 7'd0;                   // [RULE_19]
                    next_s.tx_rd      = 7'd0;
                    next_s.tx_cnt     = 8'h00;
                    next_s.act[faddr] = 1'b1;
                end
                rsc_pkg::ST_ACK, rsc_pkg::ST_ACK_PEND: begin
                    next_s.act[faddr] = 1'b1;                   // [RULE_20]
                end
                rsc_pkg::ST_RX_DEC, rsc_pkg::ST_TX_ENC: begin
                    next_s.act[faddr] = 1'b1;                   // [RULE_21] [RULE_22]
                end
                default: begin
                end
            endcase
        end

        // =================================================
        // Soft reset held while the main reset bit is low
        if (!s.main_reg[rsc_pkg::MAIN_SRST_BIT]) begin          // [RULE_03]
            next_s.cfg        = {32{rsc_pkg::CFG_RESET}};       // [RULE_01]
            next_s.tx_wr      = 7'd0;
            next_s.tx_rd      = 7'd0;
            next_s.tx_cnt     = 8'h00;
            next_s.rx_wr      = 7'd0;
            next_s.rx_rd      = 7'd0;
            next_s.rx_cnt     = 8'h00;
            next_s.calibrated = 1'b0;
        end
        if (hw_rst) begin
            next_s.main_reg   = rsc_pkg::MAIN_RESET;            // [RULE_02]
            next_s.cfg        = {32{rsc_pkg::CFG_RESET}};       // [RULE_01]
            next_s.tx_wr      = 7'd0;
            next_s.tx_rd      = 7'd0;
            next_s.tx_cnt     = 8'h00;
            next_s.rx_wr      = 7'd0;
            next_s.rx_rd      = 7'd0;
            next_s.rx_cnt     = 8'h00;
            next_s.calibrated = 1'b0;
            next_s.rstate     = rsc_pkg::RS_OFF;
            next_s.phase      = rsc_pkg::SP_IDLE;
        end

        // Registered outputs
        next_s.radio.osc_en   = next_s.rstate != rsc_pkg::RS_OFF;
        next_s.radio.synth_en = next_s.rstate == rsc_pkg::RS_RX
                                || next_s.rstate == rsc_pkg::RS_CAL
                                || next_s.rstate == rsc_pkg::RS_TX;
        next_s.radio.rx_en    = next_s.rstate == rsc_pkg::RS_RX;
        next_s.radio.tx_en    = next_s.rstate == rsc_pkg::RS_TX;
        next_s.tx_data        = next_s.txm[next_s.tx_rd];
        next_s.so             = next_s.sout[15];
    end

    // =====================================================
    // State register
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            s          <= '0;
            s.sel_s    <= 3'b111;
            s.rst_s    <= 3'b111;
            s.sel_lv   <= 1'b1;
            s.phase    <= rsc_pkg::SP_IDLE;
            s.rstate   <= rsc_pkg::RS_OFF;
            s.main_reg <= rsc_pkg::MAIN_RESET;
        end else begin
            s <= next_s;
        end
    end

    assign spi_dout_o  = s.so;
    assign tx_data_o   = s.tx_data;
    assign radio_o     = s.radio;
    assign act_o       = s.act;
    assign enc_start_o = s.enc_start;

    // =====================================================
    // Assertions
    sequence q_osc_off;
        s.main_reg[rsc_pkg::MAIN_OSC_PD] ##1 !radio_o.osc_en;
    endsequence

    property p_nop;
        @(posedge core_clk_i) disable iff (rst_i)
        fire && faddr == rsc_pkg::ST_NOP |=> act_o == 14'h0000;
    endproperty
    a_nop: assert property (p_nop) else $error("nop strobe acted"); // [RULE_10]

    property p_osc_on;
        @(posedge core_clk_i) disable iff (rst_i)
        fire && faddr == rsc_pkg::ST_OSC_ON && s.rst_s[2]
        |=> s.main_reg[1:0] == 2'b00 ##1 radio_o.osc_en;
    endproperty
    a_osc_on: assert property (p_osc_on) else $error("osc not on"); // [RULE_11]

    property p_osc_off;
        @(posedge core_clk_i) disable iff (rst_i)
        fire && faddr == rsc_pkg::ST_OSC_OFF |=> q_osc_off;
    endproperty
    a_osc_off: assert property (p_osc_off) else $error("osc not off"); // [RULE_16]

    property p_main_keep;
        @(posedge core_clk_i) disable iff (rst_i)
        !s.main_reg[rsc_pkg::MAIN_SRST_BIT] && !fire && s.rst_s[2]
        && s.phase != rsc_pkg::SP_DATA |=> $stable(s.main_reg);
    endproperty
    a_main_keep: assert property (p_main_keep) else $error("main reset"); // [RULE_02]

    property p_soft_cfg;
        @(posedge core_clk_i) disable iff (rst_i)
        !s.main_reg[rsc_pkg::MAIN_SRST_BIT]
        |=> s.cfg == {32{rsc_pkg::CFG_RESET}} && s.tx_cnt == 8'h00;
    endproperty
    a_soft_cfg: assert property (p_soft_cfg) else $error("cfg kept"); // [RULE_01]

    property p_tx_flush;
        @(posedge core_clk_i) disable iff (rst_i)
        fire && faddr == rsc_pkg::ST_TX_FLUSH |=> s.tx_cnt == 8'h00;
    endproperty
    a_tx_flush: assert property (p_tx_flush) else $error("tx kept"); // [RULE_19]

    property p_cca;
        @(posedge core_clk_i) disable iff (rst_i)
        fire && faddr == rsc_pkg::ST_TX_CCA && !cca_clear_i
        |=> !act_o[5] && !enc_start_o;
    endproperty
    a_cca: assert property (p_cca) else $error("busy channel sent"); // [RULE_15]

    property p_tx_on;
        @(posedge core_clk_i) disable iff (rst_i)
        fire && faddr == rsc_pkg::ST_TX_ON && s.rst_s[2]
        && !s.main_reg[rsc_pkg::MAIN_OSC_PD]
        && !s.main_reg[rsc_pkg::MAIN_BIAS_POWERDOWN]
        |=> radio_o.tx_en && radio_o.synth_en;
    endproperty
    a_tx_on: assert property (p_tx_on) else $error("tx not on"); // [RULE_14]

    property p_status;
        @(posedge core_clk_i) disable iff (rst_i)
        csn_fall && s.rst_s[2] |=> s.sout[15:8] == $past(stat);
    endproperty
    a_status: assert property (p_status) else $error("bad status"); // [RULE_09]

    property p_ram_keep;
        @(posedge core_clk_i) disable iff (rst_i)
        ram_byte && !tx_pop_i |=> s.tx_cnt == $past(s.tx_cnt);
    endproperty
    a_ram_keep: assert property (p_ram_keep) else $error("ram popped"); // [RULE_07]

endmodule : rsc_strobe_decoder

// ### include/rsc_pkg.sv
// Constants and types of the serial strobe and register decoder
package rsc_pkg;

    // Address byte layout
    localparam int unsigned RAM_BIT  = 7;
    localparam int unsigned READ_BIT = 6;

    // Strobe, register and queue addresses
    localparam logic [3:0] ST_NOP      = 4'h0;
    localparam logic [3:0] ST_OSC_ON   = 4'h1;
    localparam logic [3:0] ST_TX_CAL   = 4'h2;
    localparam logic [3:0] ST_RX_ON    = 4'h3;
    localparam logic [3:0] ST_TX_ON    = 4'h4;
    localparam logic [3:0] ST_TX_CCA   = 4'h5;
    localparam logic [3:0] ST_RF_OFF   = 4'h6;
    localparam logic [3:0] ST_OSC_OFF  = 4'h7;
    localparam logic [3:0] ST_RX_FLUSH = 4'h8;
    localparam logic [3:0] ST_TX_FLUSH = 4'h9;
    localparam logic [3:0] ST_ACK      = 4'hA;
    localparam logic [3:0] ST_ACK_PEND = 4'hB;
    localparam logic [3:0] ST_RX_DEC   = 4'hC;
    localparam logic [3:0] ST_TX_ENC   = 4'hD;
    localparam logic [5:0] ADDR_MAIN   = 6'h10;
    localparam logic [5:0] ADDR_CFG_LO = 6'h11;
    localparam logic [5:0] ADDR_SEC    = 6'h19;
    localparam logic [5:0] ADDR_FSM    = 6'h2C;
    localparam logic [5:0] ADDR_CFG_HI = 6'h30;
    localparam logic [5:0] ADDR_TXQ    = 6'h3E;
    localparam logic [5:0] ADDR_RXQ    = 6'h3F;

    // Main control fields and reset values
    localparam int unsigned MAIN_SRST_BIT = 15;
    localparam int unsigned MAIN_OSC_PD   = 0;
    localparam int unsigned MAIN_BIAS_POWERDOWN  = 1;
    localparam logic [15:0] MAIN_RESET    = 16'h8003;
    localparam logic [15:0] CFG_RESET     = 16'h0000;

    // Status byte fields
    localparam int unsigned STAT_OSC = 6;
    localparam int unsigned STAT_TX  = 3;
    localparam int unsigned STAT_SYN = 2;

    // Queue geometry
    localparam logic [7:0] QUEUE_DEPTH = 8'h80;

    typedef enum logic [2:0] {
        SP_IDLE = 3'b001,
        SP_ADDR = 3'b010,
        SP_DATA = 3'b100
    } rsc_spi_t;

    typedef enum logic [4:0] {
        RS_OFF  = 5'b00001,
        RS_IDLE = 5'b00010,
        RS_RX   = 5'b00100,
        RS_CAL  = 5'b01000,
        RS_TX   = 5'b10000
    } rsc_rstate_t;

    typedef struct packed {
        logic osc_en;
        logic synth_en;
        logic rx_en;
        logic tx_en;
    } rsc_radio_t;

    typedef struct packed {
        logic [2:0]        sel_s;
        logic [2:0]        sclk_s;
        logic [2:0]        si_s;
        logic [2:0]        rst_s;
        logic              sel_lv;
        logic              sclk_lv;
        rsc_spi_t          phase;
        logic [4:0]        bits;
        logic [7:0]        addr;
        logic [15:0]       sin;
        logic [15:0]       sout;
        logic [15:0]       main_reg;
        logic [31:0][15:0] cfg;
        rsc_rstate_t       rstate;
        logic              calibrated;
        logic [127:0][7:0] txm;
        logic [127:0][7:0] rxm;
        logic [6:0]        tx_wr;
        logic [6:0]        tx_rd;
        logic [6:0]        rx_wr;
        logic [6:0]        rx_rd;
        logic [6:0]        ram_ix;
        logic [7:0]        tx_cnt;
        logic [7:0]        rx_cnt;
        rsc_radio_t        radio;
        logic [13:0]       act;
        logic              enc_start;
        logic [7:0]        tx_data;
        logic              so;
    } rsc_state_t;

endpackage : rsc_pkg

// ### test/rsc_host_model.sv
// Host serial master model that drives the decoder pins
`timescale 1ns/10ps
module rsc_host_model (
    // Clock and serial pins
    input  wire logic core_clk_i,
    input  wire logic spi_dout_i,
    output logic      spi_select_low_o,
    output logic      spi_clk_o,
    output logic      spi_din_o
);
    initial begin
        spi_select_low_o = 1'b1;
        spi_clk_o        = 1'b0;
        spi_din_o        = 1'b0;
    end
    // Half period of eight core clocks, changed just after an edge
    task automatic half;
        repeat (8) @(posedge core_clk_i);
        #1;
    endtask : half
    task automatic sel(input logic lvl);
        half();
        spi_select_low_o = lvl;
    endtask : sel
    // One byte MSB first, answer taken at each rising serial edge
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            spi_din_o = tx[i];
            half();
            rx[i] = spi_dout_i;
            spi_clk_o = 1'b1;
            half();
            spi_clk_o = 1'b0;
        end
        spi_din_o = ~tx[0];
    endtask : xfer
endmodule : rsc_host_model

// ### test/radio_strobe_command_decoder_tb.sv
// Self-checking bench of the strobe and register decoder
`timescale 1ns/10ps
module radio_strobe_command_decoder_tb;
    logic                core_clk_i, rst_i, cca_clear_i, rx_push_i;
    logic                chip_reset_low_i, tx_done_i, tx_pop_i;
    logic                spi_select_low_i, spi_clk_i, spi_din_i, spi_dout_o;
    logic [7:0]          rx_data_i, tx_data_o, sb, b, d0;
    logic [13:0]         act_o, seen;
    logic                enc_start_o, enc_seen;
    logic [15:0]         w, r;
    rsc_pkg::rsc_radio_t radio_o;
    int                  num_errors, comparisons, seed;
    rsc_strobe_decoder u_dut (.core_clk_i(core_clk_i), .rst_i(rst_i),
        .chip_reset_low_i(chip_reset_low_i),
        .spi_select_low_i(spi_select_low_i),
        .spi_clk_i(spi_clk_i), .spi_din_i(spi_din_i), .spi_dout_o(spi_dout_o),
        .cca_clear_i(cca_clear_i), .tx_done_i(tx_done_i),
        .tx_pop_i(tx_pop_i),
        .rx_push_i(rx_push_i), .rx_data_i(rx_data_i), .tx_data_o(tx_data_o),
        .radio_o(radio_o), .act_o(act_o), .enc_start_o(enc_start_o));
    rsc_host_model u_host (.core_clk_i(core_clk_i), .spi_dout_i(spi_dout_o),
        .spi_select_low_o(spi_select_low_i), .spi_clk_o(spi_clk_i),
        .spi_din_o(spi_din_i));
    initial begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end
    always @(posedge core_clk_i) begin
        seen     <= rst_i ? 14'h0000 : seen | act_o;
        enc_seen <= rst_i ? 1'b0 : enc_seen | enc_start_o;
    end
    function automatic logic [7:0] stat(input logic osc);
        return {1'b0, osc, 6'h00};
    endfunction : stat
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic cmd(input logic [7:0] a);
        u_host.sel(1'b0);
        u_host.xfer(a, sb);
        u_host.sel(1'b1);
    endtask : cmd
    // Register access: address byte then sixteen data bits
    task automatic reg_io(input logic [7:0] a, input logic [15:0] d);
        u_host.sel(1'b0);
        u_host.xfer(a, sb);
        u_host.xfer(d[15:8], r[15:8]);
        u_host.xfer(d[7:0], r[7:0]);
        u_host.sel(1'b1);
    endtask : reg_io
    // Byte access: address byte then one data byte into b
    task automatic rd_byte(input logic [7:0] a);
        u_host.sel(1'b0);
        u_host.xfer(a, sb);
        u_host.xfer(8'h00, b);
        u_host.sel(1'b1);
    endtask : rd_byte
    // Radio enables after strobe n of the ordered sweep
    function automatic logic [3:0] exp_radio(input int n);
        case (n)
            2: return 4'hC;
            3: return 4'hE;
            4, 5: return 4'hD;
            default: return 4'h8;
        endcase
    endfunction : exp_radio
    task automatic finish_test;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : finish_test
    initial begin
        repeat (60000) @(posedge core_clk_i);
        num_errors++;
        finish_test();
    end
    initial begin
        seed = 41;
        rst_i = 1'b1;
        cca_clear_i = 1'b1;
        rx_push_i = 1'b0;
        rx_data_i = 8'h00;
        chip_reset_low_i = 1'b1;
        tx_done_i = 1'b0;
        tx_pop_i = 1'b0;
        repeat (5) @(posedge core_clk_i);
        #1 rst_i = 1'b0;
        cmd(8'h00);
        chk(sb, stat(1'b0));
        cmd(8'h01);
        cmd(8'h00);
        chk(sb, stat(1'b1));
        chk(radio_o.osc_en, 1'b1);
        w = 16'($random(seed)) | 16'h0001;
        reg_io(8'h19, w);
        reg_io(8'h59, 16'h0000);
        chk(r, w);
        d0 = 8'($random(seed));
        u_host.sel(1'b0);
        u_host.xfer(8'h3E, sb);
        for (int k = 0; k < 3; k++) begin
            u_host.xfer(8'(d0 + k), sb);
            chk(sb, stat(1'b1));
        end
        u_host.sel(1'b1);
        chk(tx_data_o, d0);
        rd_byte(8'h80);
        chk(b, d0);
        chk(tx_data_o, d0);
        @(posedge core_clk_i);
        #1 rx_push_i = 1'b1;
        tx_pop_i = 1'b1;
        rx_data_i = 8'($random(seed));
        repeat (2) @(posedge core_clk_i);
        #1 rx_push_i = 1'b0;
        tx_pop_i = 1'b0;
        chk(tx_data_o, 8'(d0 + 8'd2));
        rd_byte(8'h7F);
        chk(b, rx_data_i);
        for (int n = 2; n < 14; n++) begin
            if (n != 7) begin
                cmd(n[7:0]);
                chk(radio_o, exp_radio(n));
            end
        end
        chk(seen, 14'h3F7E);
        chk(enc_seen, 1'b1);
        rx_data_i = ~rx_data_i;
        rx_push_i = 1'b1;
        @(posedge core_clk_i);
        #1 rx_push_i = 1'b0;
        rd_byte(8'h7F);
        chk(b, rx_data_i);
        cmd(8'h04);
        tx_done_i = 1'b1;
        @(posedge core_clk_i);
        #1 tx_done_i = 1'b0;
        chk(radio_o, 4'hE);
        cca_clear_i = 1'b0;
        cmd(8'h05);
        chk(radio_o, 4'hE);
        cca_clear_i = 1'b1;
        reg_io(8'h10, 16'h0000);
        reg_io(8'h10, 16'h8000);
        reg_io(8'h59, 16'h0000);
        chk(r, 16'h0000);
        reg_io(8'h50, 16'h0000);
        chk(r, 16'h8000);
        reg_io(8'h19, w);
        chip_reset_low_i = 1'b0;
        repeat (6) @(posedge core_clk_i);
        #1 chip_reset_low_i = 1'b1;
        reg_io(8'h59, 16'h0000);
        chk(r, 16'h0000);
        reg_io(8'h50, 16'h0000);
        chk(r, 16'h8003);
        cmd(8'h01);
        cmd(8'h07);
        chk(radio_o, 4'h0);
        chk(seen[7], 1'b1);
        finish_test();
    end
endmodule : radio_strobe_command_decoder_tb
